// ---- rtl/dfh_map.vh ----
// Constants for the descriptor flag and field handling block.
`ifndef DFH_MAP_VH
`define DFH_MAP_VH
// Descriptor flag bit positions.
`define DFH_FLAG_FENCE 0
`define DFH_FLAG_BOF 1
`define DFH_FLAG_CRAV 2
`define DFH_FLAG_RCR 3
`define DFH_FLAG_RCI 4
// Descriptor byte offsets of the common fields.
`define DFH_OFF_CRA 8
`define DFH_OFF_SRC 16
`define DFH_OFF_DST 24
`define DFH_OFF_XSIZE 32
`define DFH_OFF_IHANDLE 36
// Record and read geometry.
`define DFH_REC_ALIGN_MASK 64'h0000_0000_0000_001f
`define DFH_SRC_ALIGN_MASK 64'h0000_0000_0000_003f
// Operation status codes.
`define DFH_ST_SUCCESS 6'h01
`define DFH_ST_FALSE_PRED 6'h02
`define DFH_ST_PARTIAL 6'h05
`define DFH_ST_INVALID_FLAGS 6'h10
`define DFH_ST_ABANDONED 6'h11
`define DFH_ST_BAD_SIZE 6'h13
`define DFH_ST_BAD_RECADDR 6'h14
`define DFH_ST_PAGE_FAULT 6'h03
`define DFH_ST_GENERIC_ERR 6'h1e
// Opcodes that matter to flag checking and second-source selection.
`define DFH_OP_NOOP 8'h00
`define DFH_OP_BATCH 8'h01
`define DFH_OP_DRAIN 8'h02
`define DFH_OP_COMPARE 8'h09
// AXI4-Lite register offsets.
`define DFH_REG_CTRL 12'h000
`define DFH_REG_WQMAX 12'h004
`define DFH_REG_WQBATCH 12'h008
`define DFH_REG_STATUS 12'h00c
`define DFH_REG_SWERR 12'h010
`define DFH_REG_COUNT 12'h014
// Reset values.
`define DFH_CTRL_RST 32'h0000_0000
`define DFH_WQMAX_RST 32'h0020_0000
`define DFH_WQBATCH_RST 32'h0000_0020
// Device capability caps.
`define DFH_CAP_MAX_XSIZE 32'h8000_0000
`define DFH_CAP_MAX_BATCH 32'h0000_0400
// AXI responses.
`define DFH_RESP_OKAY 2'b00
`define DFH_RESP_SLVERR 2'b10
`endif

// ---- rtl/dfh_core.v ----
// Descriptor flag and field interpreter with an AXI4-Lite register slave.
`timescale 1ns/10ps
`include "dfh_map.vh"
module dfh_core (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address.
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address.
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Descriptor submission.
  input wire desc_valid,
  output wire desc_ready,
  input wire [7:0] desc_opcode,
  input wire [23:0] desc_flags,
  input wire desc_priv,
  input wire desc_in_batch,
  input wire desc_batch_first,
  input wire [63:0] desc_rec_addr,
  input wire [63:0] desc_src_addr,
  input wire [63:0] desc_dst_addr,
  input wire [31:0] desc_xfer_size,
  input wire [15:0] desc_int_handle,
  // Operation engine start and finish.
  output reg op_start,
  output reg [63:0] op_src_addr,
  output reg [63:0] op_src_read_addr,
  output reg [31:0] op_src_keep_bytes,
  output reg [63:0] op_dst_addr,
  output reg op_dst_is_src2,
  output reg [31:0] op_xfer_size,
  input wire op_done,
  input wire [5:0] op_status,
  // Page fault reporting from the engine.
  input wire pf_valid,
  input wire pf_critical,
  input wire pf_resolved,
  output reg pf_wait,
  output reg pf_partial,
  // Completion record writer.
  output reg rec_write,
  output reg [63:0] rec_addr,
  output reg [7:0] rec_status,
  output reg [23:0] rec_invalid_flags,
  input wire rec_done,
  // Completion interrupt.
  output reg cmpl_irq,
  output reg [15:0] cmpl_irq_handle,
  // Event log.
  output reg evlog_write,
  output reg [7:0] evlog_status
);

  // Controller states.
  localparam ST_IDLE = 3'd0;
  localparam ST_FENCE = 3'd1;
  localparam ST_RUN = 3'd2;
  localparam ST_BLOCK = 3'd3;
  localparam ST_RECORD = 3'd4;
  localparam ST_IRQ = 3'd5;
  localparam ST_LOG = 3'd6;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  ////////////////////////////////////////////////////////////////////////////

  // Control: bit0 user interrupts enable, bit1 PASID enable, bit2 block-on-fault enable,
  // bit3 event log enable, bit4 drain variant uses destination as second source.
  reg [31:0] ctrl_reg;
  // Queue maximum transfer size and maximum batch size.
  reg [31:0] wq_max_reg;
  reg [31:0] wq_batch_reg;
  // Software error register, first error held until cleared by writing one.
  reg [31:0] swerr_reg;
  // Completed descriptor count.
  reg [31:0] count_reg;
  // Bus handshake holding registers.
  reg aw_full_reg;
  reg [11:0] aw_addr_reg;
  reg w_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // Controller state.
  reg [2:0] state_reg;
  reg batch_fail_reg;
  reg batch_busy_reg;
  reg want_rec_reg;
  reg want_irq_reg;
  reg [5:0] final_st_reg;
  reg [23:0] bad_flags_reg;

  // Merge the write strobes into an old word.
  function [31:0] dfh_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      dfh_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          dfh_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Decode whether an address hits a register.
  function dfh_mapped;
    input [11:0] a;
    begin
      dfh_mapped = (a == `DFH_REG_CTRL) || (a == `DFH_REG_WQMAX) ||
                   (a == `DFH_REG_WQBATCH) || (a == `DFH_REG_STATUS) ||
                   (a == `DFH_REG_SWERR) || (a == `DFH_REG_COUNT);
    end
  endfunction

  // Address and data are each taken alone; the response waits for both.
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

  // Set when the controller logs an error into the software error register.
  wire swerr_set;
  wire [31:0] swerr_val;
  // A clear written in the same cycle as a new error must not swallow it.
  wire swerr_clr = wr_go && (aw_addr_reg == `DFH_REG_SWERR) && w_strb_reg[0] && w_data_reg[0];

  // Write channel and register updates; a hardware error set wins over a clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DFH_RESP_OKAY;
      ctrl_reg <= `DFH_CTRL_RST;
      wq_max_reg <= `DFH_WQMAX_RST;
      wq_batch_reg <= `DFH_WQBATCH_RST;
      swerr_reg <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= dfh_mapped(aw_addr_reg) ? `DFH_RESP_OKAY : `DFH_RESP_SLVERR;
        case (aw_addr_reg)
          `DFH_REG_CTRL: begin
            ctrl_reg <= dfh_merge(ctrl_reg, w_data_reg, w_strb_reg);
          end
          `DFH_REG_WQMAX: begin
            wq_max_reg <= dfh_merge(wq_max_reg, w_data_reg, w_strb_reg);
          end
          `DFH_REG_WQBATCH: begin
            wq_batch_reg <= dfh_merge(wq_batch_reg, w_data_reg, w_strb_reg);
          end
          `DFH_REG_SWERR: begin
            if (w_strb_reg[0] && w_data_reg[0]) begin
              swerr_reg <= 32'h0000_0000;
            end
          end
          default: begin
          end
        endcase
      end
      if (swerr_set && (!swerr_reg[0] || swerr_clr)) begin
        swerr_reg <= swerr_val;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DFH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dfh_mapped(s_axi_araddr) ? `DFH_RESP_OKAY : `DFH_RESP_SLVERR;
      case (s_axi_araddr)
        `DFH_REG_CTRL: s_axi_rdata <= ctrl_reg;
        `DFH_REG_WQMAX: s_axi_rdata <= wq_max_reg;
        `DFH_REG_WQBATCH: s_axi_rdata <= wq_batch_reg;
        `DFH_REG_STATUS: s_axi_rdata <= {26'h0, batch_fail_reg, batch_busy_reg, 1'b0, state_reg};
        `DFH_REG_SWERR: s_axi_rdata <= swerr_reg;
        `DFH_REG_COUNT: s_axi_rdata <= count_reg;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor checks.
  ////////////////////////////////////////////////////////////////////////////

  wire f_fence = desc_flags[`DFH_FLAG_FENCE];
  wire f_bof = desc_flags[`DFH_FLAG_BOF];
  wire f_crav = desc_flags[`DFH_FLAG_CRAV];
  wire f_rcr = desc_flags[`DFH_FLAG_RCR];
  wire f_rci = desc_flags[`DFH_FLAG_RCI];
  wire is_batch = (desc_opcode == `DFH_OP_BATCH);
  wire rci_rsvd = ctrl_reg[1] && !ctrl_reg[0] && !desc_priv;
  wire bof_rsvd = !ctrl_reg[2] || (desc_opcode == `DFH_OP_NOOP) ||
                  (desc_opcode == `DFH_OP_DRAIN) || is_batch;
  wire fence_rsvd = !desc_in_batch;
  wire [23:0] bad_flags = {19'h0, f_rci && rci_rsvd, 1'b0, 1'b0, f_bof && bof_rsvd,
                           f_fence && fence_rsvd};
  // size capped by queue and device maxima.
  wire [31:0] max_xfer = (wq_max_reg < `DFH_CAP_MAX_XSIZE) ? wq_max_reg : `DFH_CAP_MAX_XSIZE;
  wire [31:0] max_batch = (wq_batch_reg < `DFH_CAP_MAX_BATCH) ? wq_batch_reg
                          : `DFH_CAP_MAX_BATCH;
  wire size_bad = (desc_xfer_size == 32'h0) ||
                  (is_batch ? (desc_xfer_size < 32'h2 || desc_xfer_size > max_batch)
                            : (desc_xfer_size > max_xfer));
  wire rec_bad = f_crav && ((desc_rec_addr & `DFH_REC_ALIGN_MASK) != 64'h0);
  // widen unaligned source reads to 64-byte chunks.
  wire src_unal = ((desc_src_addr | {32'h0, desc_xfer_size}) & `DFH_SRC_ALIGN_MASK) != 64'h0;
  wire [63:0] src_base = desc_src_addr & ~`DFH_SRC_ALIGN_MASK;

  assign desc_ready = (state_reg == ST_IDLE);
  wire take = desc_valid && desc_ready;
  wire [5:0] pre_st = (bad_flags != 24'h0) ? `DFH_ST_INVALID_FLAGS :
                      size_bad ? `DFH_ST_BAD_SIZE :
                      rec_bad ? `DFH_ST_BAD_RECADDR : `DFH_ST_SUCCESS;
  wire need_rec = want_rec_reg || !((final_st_reg == `DFH_ST_SUCCESS) ||
                  (final_st_reg == `DFH_ST_FALSE_PRED) || (final_st_reg == `DFH_ST_PARTIAL));
  wire normal = (final_st_reg == `DFH_ST_SUCCESS) || (final_st_reg == `DFH_ST_FALSE_PRED);
  reg crav_reg;
  // Block-on-fault honoured for the descriptor in flight, latched on take.
  reg bof_go_reg;
  assign swerr_set = (state_reg == ST_LOG) && !ctrl_reg[3];
  assign swerr_val = {18'h0, final_st_reg, 7'h0, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Controller.
  ////////////////////////////////////////////////////////////////////////////

  // Sequences fence, run, fault wait, record, interrupt and logging.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      batch_fail_reg <= 1'b0;
      batch_busy_reg <= 1'b0;
      want_rec_reg <= 1'b0;
      want_irq_reg <= 1'b0;
      final_st_reg <= `DFH_ST_SUCCESS;
      bad_flags_reg <= 24'h0;
      crav_reg <= 1'b0;
      bof_go_reg <= 1'b0;
      count_reg <= 32'h0;
      op_start <= 1'b0;
      op_src_addr <= 64'h0;
      op_src_read_addr <= 64'h0;
      op_src_keep_bytes <= 32'h0;
      op_dst_addr <= 64'h0;
      op_dst_is_src2 <= 1'b0;
      op_xfer_size <= 32'h0;
      pf_wait <= 1'b0;
      pf_partial <= 1'b0;
      rec_write <= 1'b0;
      rec_addr <= 64'h0;
      rec_status <= 8'h00;
      rec_invalid_flags <= 24'h0;
      cmpl_irq <= 1'b0;
      cmpl_irq_handle <= 16'h0;
      evlog_write <= 1'b0;
      evlog_status <= 8'h00;
    end else begin
      op_start <= 1'b0;
      cmpl_irq <= 1'b0;
      evlog_write <= 1'b0;
      pf_partial <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            // A new batch clears the failure memory of the last one.
            if (desc_batch_first || !desc_in_batch) begin
              batch_fail_reg <= 1'b0;
            end
            batch_busy_reg <= desc_in_batch;
            want_rec_reg <= f_rcr && f_crav;
            want_irq_reg <= f_rci && !rci_rsvd;
            crav_reg <= f_crav;
            bof_go_reg <= f_bof && !bof_rsvd;
            bad_flags_reg <= bad_flags;
            rec_addr <= desc_rec_addr;
            cmpl_irq_handle <= (f_rci && !rci_rsvd) ? desc_int_handle : 16'h0;
            op_src_addr <= desc_src_addr;
            op_src_read_addr <= src_unal ? src_base : desc_src_addr;
            op_src_keep_bytes <= desc_xfer_size;
            op_dst_addr <= desc_dst_addr;
            op_dst_is_src2 <= (desc_opcode == `DFH_OP_COMPARE) ||
                              ((desc_opcode == `DFH_OP_DRAIN) && ctrl_reg[4]);
            op_xfer_size <= desc_xfer_size;
            if (desc_in_batch && !desc_batch_first && batch_fail_reg &&
                (f_fence || batch_fail_reg)) begin
              final_st_reg <= `DFH_ST_ABANDONED;
              state_reg <= ST_RECORD;
            end else if (pre_st != `DFH_ST_SUCCESS) begin
              final_st_reg <= pre_st;
              state_reg <= ST_RECORD;
            end else if (desc_in_batch && f_fence) begin
              state_reg <= ST_FENCE;
            end else begin
              op_start <= 1'b1;
              state_reg <= ST_RUN;
            end
          end
        end
        ST_FENCE: begin
          // Earlier members are serialised here, so they have already ended.
          op_start <= 1'b1;
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (pf_valid) begin
            if (pf_critical || bof_go_reg) begin
              pf_wait <= 1'b1;
              state_reg <= ST_BLOCK;
            end else begin
              pf_partial <= 1'b1;
              final_st_reg <= `DFH_ST_PAGE_FAULT;
              state_reg <= ST_RECORD;
            end
          end else if (op_done) begin
            final_st_reg <= (op_status == 6'h00) ? `DFH_ST_GENERIC_ERR : op_status;
            state_reg <= ST_RECORD;
          end
        end
        ST_BLOCK: begin
          if (pf_resolved) begin
            pf_wait <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        ST_RECORD: begin
          if (!normal) begin
            batch_fail_reg <= batch_busy_reg;
          end
          if (!rec_write) begin
            if (crav_reg && need_rec) begin
              rec_write <= 1'b1;
              rec_status <= {2'b00, final_st_reg};
              rec_invalid_flags <= bad_flags_reg;
            end else if (!crav_reg && !normal) begin
              state_reg <= ST_LOG;
            end else begin
              state_reg <= ST_IRQ;
            end
          end else if (rec_done) begin
            rec_write <= 1'b0;
            state_reg <= ST_IRQ;
          end
        end
        ST_LOG: begin
          // log to event log when enabled.
          evlog_write <= ctrl_reg[3];
          evlog_status <= {2'b00, final_st_reg};
          state_reg <= ST_IRQ;
        end
        ST_IRQ: begin
          cmpl_irq <= want_irq_reg;
          count_reg <= count_reg + 32'h1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dfh_core

// ---- tb/dfh_assertions.sv ----
// Checker for the descriptor flag and field handling block.
`timescale 1ns/10ps
module dfh_assertions (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Watched ports.
  input wire desc_valid,
  input wire desc_ready,
  input wire op_start,
  input wire [63:0] op_src_addr,
  input wire [63:0] op_src_read_addr,
  input wire [31:0] op_xfer_size,
  input wire pf_valid,
  input wire pf_critical,
  input wire pf_wait,
  input wire pf_partial,
  input wire rec_write,
  input wire [7:0] rec_status,
  input wire rec_done,
  input wire cmpl_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  property p_rec_nonzero; rec_write |-> rec_status != 8'h00; endproperty
  a_rec_nonzero: assert property (p_rec_nonzero) else $error("zero record status");
  property p_irq_after_rec; cmpl_irq |-> !rec_write; endproperty
  a_irq_after_rec: assert property (p_irq_after_rec) else $error("irq during record");
  property p_irq_pulse; cmpl_irq |=> !cmpl_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  property p_one_desc; desc_valid && desc_ready |=> !desc_ready; endproperty
  a_one_desc: assert property (p_one_desc) else $error("second descriptor open");
  // The read may start below the source but never a line or more below it.
  property p_overread;
    op_start |-> op_src_read_addr <= op_src_addr && op_src_addr - op_src_read_addr < 64'h40;
  endproperty
  a_overread: assert property (p_overread) else $error("bad source read start");
  property p_size_nonzero; op_start |-> op_xfer_size != 32'h0; endproperty
  a_size_nonzero: assert property (p_size_nonzero) else $error("zero size started");
  property p_crit_wait; pf_valid && pf_critical |-> ##[1:2] pf_wait; endproperty
  a_crit_wait: assert property (p_crit_wait) else $error("critical fault not waited");
  property p_partial_free; pf_partial |-> !pf_wait; endproperty
  a_partial_free: assert property (p_partial_free) else $error("partial while waiting");
  property p_rec_hold; rec_write && !rec_done |=> rec_write; endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("record dropped early");
  c_irq: cover property (cmpl_irq);
  c_rec: cover property (rec_write && rec_done);
  c_wait: cover property (pf_wait);
endmodule // dfh_assertions
bind dfh_core dfh_assertions dfh_assertions_i (.aclk, .aresetn, .desc_valid, .desc_ready,
  .op_start, .op_src_addr, .op_src_read_addr, .op_xfer_size, .pf_valid, .pf_critical,
  .pf_wait, .pf_partial, .rec_write, .rec_status, .rec_done, .cmpl_irq);

// ---- tb/dfh_engine_model.sv ----
// Behavioural model of the operation engine and the record writer.
`timescale 1ns/10ps
module dfh_engine_model (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Engine controls from the bench.
  input wire [5:0] fin_status,
  input wire [3:0] lat,
  input wire hold,
  // Engine side.
  input wire op_start,
  output reg op_done,
  output reg [5:0] op_status,
  // Record writer side.
  input wire rec_write,
  output reg rec_done
);
  reg [3:0] op_cnt; // Cycles left in the operation.
  reg op_busy; // Operation under way.
  reg [3:0] rec_cnt; // Cycles left in the record write.
  reg rec_gap; // Done given, waiting for the request to fall.
  // Status is only valid with op_done, so it churns otherwise.
  always @(posedge aclk) begin
    op_done <= 1'b0;
    op_status <= ~op_status;
    if (!aresetn) begin
      op_busy <= 1'b0;
      op_cnt <= 4'h0;
      op_status <= 6'h00;
    end else if (op_start) begin
      op_busy <= 1'b1;
      op_cnt <= lat;
    end else if (op_busy && !hold) begin
      if (op_cnt == 4'h0) begin
        op_busy <= 1'b0;
        op_done <= 1'b1;
        op_status <= fin_status;
      end else begin
        op_cnt <= op_cnt - 4'h1;
      end
    end
  end
  // One done pulse per record request, never a second while it falls.
  always @(posedge aclk) begin
    rec_done <= 1'b0;
    if (!aresetn || !rec_write) begin
      rec_cnt <= lat;
      rec_gap <= 1'b0;
    end else if (!rec_gap) begin
      if (rec_cnt == 4'h0) begin
        rec_done <= 1'b1;
        rec_gap <= 1'b1;
      end else begin
        rec_cnt <= rec_cnt - 4'h1;
      end
    end
  end
endmodule // dfh_engine_model

// ---- tb/testbench.sv ----
// Self-checking bench for the descriptor flag and field handling block.
`timescale 1ns/10ps
module testbench;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, desc_xfer_size, ctrl, wqmax;
  reg [3:0] s_axi_wstrb, lat;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, op_src_keep_bytes, op_xfer_size;
  reg desc_valid, desc_priv, desc_in_batch, desc_batch_first, hold, bfail;
  reg pf_valid, pf_critical, pf_resolved, m_start, m_rec, m_irq, m_ev;
  reg [7:0] desc_opcode, m_rst, m_est;
  reg [23:0] desc_flags;
  reg [63:0] desc_rec_addr, desc_src_addr, desc_dst_addr, m_ra;
  reg [15:0] desc_int_handle, m_ih;
  reg [5:0] fin_status;
  wire desc_ready, op_start, op_dst_is_src2, op_done, pf_wait, pf_partial;
  wire rec_write, rec_done, cmpl_irq, evlog_write;
  wire [63:0] op_src_addr, op_src_read_addr, op_dst_addr, rec_addr;
  wire [5:0] op_status;
  wire [7:0] rec_status, evlog_status;
  wire [23:0] rec_invalid_flags;
  wire [15:0] cmpl_irq_handle;
  integer n_mismatch, cmp_count, seed, k;
  reg [31:0] r;
  dfh_core dfh_core_i (.*);
  dfh_engine_model dfh_engine_model_i (.*);
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  // Latch what the block reports during one descriptor.
  always @(posedge aclk) begin
    if (op_start) m_start = 1'b1;
    if (rec_write && rec_done) begin
      m_rec = 1'b1;
      m_rst = rec_status;
      m_ra = rec_addr;
    end
    if (cmpl_irq) begin
      m_irq = 1'b1;
      m_ih = cmpl_irq_handle;
    end
    if (evlog_write) begin
      m_ev = 1'b1;
      m_est = evlog_status;
    end
  end
  task summarize;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A wait that ran out ends the run as a failure.
  task tmo(input integer i);
    if (i >= 200) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  endtask
  task axi_wr(input [11:0] a, input [31:0] d, input [1:0] er);
    integer i;
    reg dn;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      dn = 1'b0;
      for (i = 0; i < 200 && !dn; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          dn = 1'b1;
          s_axi_bready <= 1'b0;
          chk(s_axi_bresp, er);
        end
      end
      tmo(i);
    end
  endtask
  task axi_rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    integer i;
    reg dn;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      dn = 1'b0;
      for (i = 0; i < 200 && !dn; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          dn = 1'b1;
          s_axi_rready <= 1'b0;
          chk({s_axi_rresp, s_axi_rdata}, {er, ed});
        end
      end
      tmo(i);
    end
  endtask
  // Expected status of a descriptor, with bit 8 set when a record is due.
  function [8:0] exp_rec(input [23:0] f, input pr, input inb, input fst,
                         input [63:0] ra, input [31:0] sz, input [5:0] st);
    reg [7:0] s;
    begin
      if (inb && !fst && bfail) s = 8'h11;
      else if ((f[4] && ctrl[1] && !ctrl[0] && !pr) || (f[0] && !inb) ||
               (f[1] && !ctrl[2])) s = 8'h10;
      else if (sz == 32'h0 || sz > wqmax) s = 8'h13;
      else if (f[2] && ra[4:0] != 5'h00) s = 8'h14;
      else if (st == 6'h00) s = 8'h1e;
      else s = {2'b00, st};
      exp_rec = {f[2] && (f[3] || !(s == 8'h01 || s == 8'h02 || s == 8'h05)), s};
    end
  endfunction
  task run(input [23:0] f, input pr, input inb, input fst, input [63:0] ra,
           input [31:0] sz, input [5:0] st);
    integer i;
    reg [8:0] e;
    reg go;
    begin
      e = exp_rec(f, pr, inb, fst, ra, sz, st);
      go = e[7:0] < 8'h10 || e[7:0] == 8'h1e;
      {m_start, m_rec, m_irq, m_ev} = 4'h0;
      fin_status <= st;
      desc_valid <= 1'b1;
      desc_opcode <= 8'h03; // no result-producing operation is sent.
      desc_flags <= f;
      desc_priv <= pr;
      desc_in_batch <= inb;
      desc_batch_first <= fst;
      desc_rec_addr <= ra;
      desc_src_addr <= {$random(seed), $random(seed)};
      desc_dst_addr <= {$random(seed), $random(seed)};
      desc_xfer_size <= sz;
      desc_int_handle <= $random(seed);
      @(posedge aclk);
      desc_valid <= 1'b0;
      i = 0;
      do begin
        @(posedge aclk);
        i = i + 1;
      end while (desc_ready !== 1'b1 && i < 200);
      tmo(i);
      repeat (2) @(posedge aclk);
      if (inb) bfail = (fst ? 1'b0 : bfail) | (e[7:0] != 8'h01 && e[7:0] != 8'h02);
      chk(m_start, go);
      chk(m_rec, e[8]);
      if (e[8]) chk({m_rst, m_ra[55:0]}, {e[7:0], ra[55:0]});
      if (go) chk(m_irq, f[4]);
      if (go && f[4]) chk(m_ih, desc_int_handle);
      chk(m_ev, !f[2] && ctrl[3] && e[7:0] != 8'h01 && e[7:0] != 8'h02);
      if (m_ev) chk(m_est, e[7:0]);
    end
  endtask
  initial begin
    seed = 32'hcc97311e;
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
    {s_axi_rready, desc_valid, desc_priv, desc_in_batch, desc_batch_first} = 5'h00;
    {pf_valid, pf_critical, pf_resolved, hold, bfail} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, desc_xfer_size, desc_opcode} = 0;
    {desc_flags, desc_rec_addr, desc_src_addr, desc_dst_addr, desc_int_handle} = 0;
    s_axi_wstrb = 4'hf;
    lat = 4'h2;
    fin_status = 6'h01;
    {n_mismatch, cmp_count} = 0;
    ctrl = 32'h0000_000e;
    wqmax = 32'h0000_1000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(12'h004, 32'h0020_0000, 2'b00);
    axi_rd(12'h008, 32'h0000_0020, 2'b00);
    axi_rd(12'h040, 32'h0, 2'b10);
    axi_wr(12'h040, 32'h1, 2'b10);
    axi_wr(12'h004, wqmax, 2'b00);
    axi_wr(12'h000, ctrl, 2'b00);
    axi_rd(12'h000, ctrl, 2'b00);
    run(24'h1c, 0, 0, 0, 64'h40, 32'h10, 6'h01);
    run(24'h1c, 1, 0, 0, 64'h40, 32'h10, 6'h01);
    run(24'h0c, 1, 0, 0, 64'h40, 32'h1000, 6'h02);
    run(24'h0c, 1, 0, 0, 64'h40, 32'h1001, 6'h01);
    run(24'h04, 1, 0, 0, 64'h40, 32'h0, 6'h01);
    run(24'h0c, 1, 0, 0, 64'h48, 32'h10, 6'h01);
    run(24'h0d, 1, 0, 0, 64'h40, 32'h10, 6'h01);
    run(24'h00, 1, 0, 0, 64'h0, 32'h0, 6'h01);
    run(24'h0c, 1, 1, 1, 64'h40, 32'h10, 6'h0a);
    run(24'h0d, 1, 1, 0, 64'h40, 32'h10, 6'h01);
    run(24'h0c, 1, 1, 0, 64'h40, 32'h10, 6'h01);
    run(24'h0c, 1, 1, 1, 64'h40, 32'h10, 6'h01);
    run(24'h0d, 1, 1, 0, 64'h40, 32'h10, 6'h01);
    for (k = 0; k < 24; k = k + 1) begin
      r = $random(seed);
      lat <= r[11:8];
      run({19'h0, r[4], r[3] & r[2], r[2:1], 1'b0}, 1'b1, 1'b0, 1'b0,
          {32'h0, $random(seed)} & 64'hffff_ffe0, ($random(seed) & 32'hfff) + 32'h1,
          r[7] ? 6'h0a : (r[6] ? 6'h00 : {3'h0, r[5], 1'b0, r[1] | r[5]}));
    end
    lat <= 4'h8;
    fork
      run(24'h0c, 1, 0, 0, 64'h40, 32'h10, 6'h01);
      begin
        repeat (4) @(posedge aclk);
        pf_valid <= 1'b1;
        pf_critical <= 1'b1;
        hold <= 1'b1;
        @(posedge aclk);
        pf_valid <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(pf_wait, 1'b1);
        pf_resolved <= 1'b1;
        hold <= 1'b0;
        @(posedge aclk);
        pf_resolved <= 1'b0;
        pf_critical <= 1'b0;
      end
    join
    fork
      run(24'h04, 1, 0, 0, 64'h40, 32'h10, 6'h03);
      begin
        repeat (4) @(posedge aclk);
        pf_valid <= 1'b1;
        @(posedge aclk);
        pf_valid <= 1'b0;
      end
    join
    ctrl = 32'h0000_0002;
    axi_wr(12'h000, ctrl, 2'b00);
    run(24'h06, 1, 0, 0, 64'h40, 32'h10, 6'h01);
    run(24'h00, 1, 0, 0, 64'h0, 32'h0, 6'h01);
    axi_rd(12'h010, 32'h0000_1301, 2'b00);
    summarize;
  end
endmodule // testbench
